// file: hw/adc_cfg_pkg.sv
// Constants, register map and types for the converter mode and input configuration block.
// Assumes a single system clock; all serial pins are synchronised before use.
package adc_cfg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int FRAME_BITS = 24;
    localparam int NUM_CONV = 4;
    localparam int SRC_W = 5;

    // Register offsets
    localparam logic [7:0] ADDR_SOFTWARE_REINIT = 8'h00;
    localparam logic [7:0] ADDR_OPERATING_MODE_AND_DIVIDER = 8'h31;
    localparam logic [7:0] ADDR_CROSSPOINT_SELECT_LOW_PAIR = 8'h3a;
    localparam logic [7:0] ADDR_CROSSPOINT_SELECT_HIGH_PAIR = 8'h3b;
    localparam logic [7:0] ADDR_FULL_SCALE_TRIM = 8'h55;

    // Address byte bit that turns a frame into a readback
    localparam int READ_FLAG_BIT = 7;

    // Field positions
    localparam int REINIT_BIT = 0;
    localparam int PRECISION_BIT = 3;
    localparam int INTERLEAVE_LSB = 0;
    localparam int INTERLEAVE_W = 3;
    localparam int CLK_DIV_LSB = 8;
    localparam int CLK_DIV_W = 2;
    localparam int XP_LOW_LSB = 0;
    localparam int XP_HIGH_LSB = 8;
    localparam int TRIM_LSB = 0;
    localparam int TRIM_W = 6;

    // Interleave select codes
    localparam logic [2:0] ILV_SINGLE = 3'h1;
    localparam logic [2:0] ILV_DUAL = 3'h2;
    localparam logic [2:0] ILV_QUAD = 3'h4;

    // Crosspoint source codes, one-hot above bit 0
    localparam logic [4:0] XP_INPUT_1 = 5'h02;
    localparam logic [4:0] XP_INPUT_2 = 5'h04;
    localparam logic [4:0] XP_INPUT_3 = 5'h08;
    localparam logic [4:0] XP_INPUT_4 = 5'h10;

    // Reset values
    localparam logic RST_PRECISION = 1'b0;
    localparam logic [2:0] RST_INTERLEAVE = ILV_QUAD;
    localparam logic [1:0] RST_CLK_DIV = 2'h0;
    localparam logic [5:0] RST_TRIM = 6'h20;
    localparam logic [5:0] TRIM_ZERO = 6'h20;

    // Branches combined per output channel
    localparam logic [3:0] BRANCHES_SINGLE = 4'h8;
    localparam logic [3:0] BRANCHES_DUAL = 4'h4;
    localparam logic [3:0] BRANCHES_QUAD = 4'h2;
    localparam logic [3:0] BRANCHES_PRECISION = 4'h1;

    typedef enum logic [2:0] {
        MODE_SINGLE = 3'b000,
        MODE_DUAL = 3'b001,
        MODE_QUAD = 3'b010,
        MODE_PRECISION = 3'b011,
        MODE_INVALID = 3'b100
    } mode_type;

    typedef logic [NUM_CONV-1:0][SRC_W-1:0] xp_array_type;
    typedef logic [NUM_CONV-1:0][NUM_CONV-1:0] chan_mask_type;
    typedef logic [NUM_CONV-1:0][1:0] input_idx_type;

endpackage

// file: hw/cfg_bus_if.sv
// Carrier between the serial port front end and the register file.
// Both ends sit on the same clock; the write strobe is a one-cycle pulse.
`timescale 1ns/100ps
interface cfg_bus_if;
    logic wr_stb;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [7:0] rd_addr;
    logic [15:0] rdata;

    modport port (
        output wr_stb,
        output addr,
        output wdata,
        output rd_addr,
        input rdata
    );

    modport regs (
        input wr_stb,
        input addr,
        input wdata,
        input rd_addr,
        output rdata
    );
endinterface

// file: hw/serial_cfg_port.sv
// Serial control port: 24-bit frames, address byte then 16 data bits, MSB first.
// Pins are asynchronous; serial clock must stay well below a quarter of the system clock.
`timescale 1ns/100ps
module serial_cfg_port
    import adc_cfg_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sclk,
    input wire logic i_spi_sdata,
    output logic o_spi_sdout,
    output logic o_spi_sdout_oe_n,
    cfg_bus_if.port bus
);
    import adc_cfg_pkg::*;

    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] sck_s;
        logic [1:0] sd_s;
        logic [4:0] cnt;
        logic [23:0] sh_in;
        logic [15:0] sh_out;
        logic rd;
        logic sdo;
        logic oe_n;
        logic wr;
        logic [7:0] addr;
        logic [15:0] wdata;
    } port_state_type;

    localparam port_state_type PORT_RESET = '{cs_s: 3'h7, oe_n: 1'b1, default: '0};

    port_state_type q, d;
    logic cs_rise, sck_rise, sck_fall;

    assign cs_rise = q.cs_s[1] & ~q.cs_s[2];
    assign sck_rise = q.sck_s[1] & ~q.sck_s[2];
    assign sck_fall = ~q.sck_s[1] & q.sck_s[2];

    always_comb begin
        d = q;
        d.wr = 1'b0;
        d.cs_s = {q.cs_s[1:0], i_spi_cs_n};
        d.sck_s = {q.sck_s[1:0], i_spi_sclk};
        d.sd_s = {q.sd_s[0], i_spi_sdata};
        if (cs_rise) begin
            // Only complete 24-bit write frames land
            if (q.cnt == 5'(FRAME_BITS) && !q.rd) begin
                d.wr = 1'b1;
                d.wdata = q.sh_in[15:0];
            end
            d.cnt = 5'h00;
            d.rd = 1'b0;
            d.oe_n = 1'b1;
        end else if (q.cs_s[1]) begin
            d.cnt = 5'h00;
            d.oe_n = 1'b1;
        end else begin
            if (sck_rise) begin
                d.sh_in = {q.sh_in[22:0], q.sd_s[1]};
                if (q.cnt != 5'h1f) begin
                    d.cnt = q.cnt + 5'h01;
                end
                if (q.cnt == 5'h07) begin
                    d.addr = {1'b0, q.sh_in[5:0], q.sd_s[1]};
                    d.rd = q.sh_in[6];
                end
            end
            if (sck_fall && q.rd) begin
                if (q.cnt == 5'h08) begin
                    d.sdo = bus.rdata[15];
                    d.sh_out = {bus.rdata[14:0], 1'b0};
                    d.oe_n = 1'b0;
                end else begin
                    d.sdo = q.sh_out[15];
                    d.sh_out = {q.sh_out[14:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            q <= PORT_RESET;
        end else begin
            q <= d;
        end
    end

    assign bus.wr_stb = q.wr;
    assign bus.addr = q.addr;
    assign bus.wdata = q.wdata;
    assign bus.rd_addr = q.addr;
    assign o_spi_sdout = q.sdo;
    assign o_spi_sdout_oe_n = q.oe_n;
endmodule

// file: hw/sample_clock_divider.sv
// Sample-rate tick generator: one pulse every 1, 2, 4 or 8 input clocks.
// A new divider code restarts the count so no short period is emitted.
`timescale 1ns/100ps
module sample_clock_divider
    import adc_cfg_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [1:0] i_div_code,
    output logic o_tick
);
    import adc_cfg_pkg::*;

    typedef struct packed {
        logic [1:0] code;
        logic [2:0] cnt;
        logic tick;
    } div_state_type;

    localparam div_state_type DIV_RESET = '0;

    div_state_type q, d;
    logic [2:0] last;

    always_comb begin
        last = 3'((4'h1 << i_div_code) - 4'h1);
        d = q;
        d.code = i_div_code;
        d.tick = 1'b0;
        if (q.code != i_div_code) begin
            d.cnt = 3'h0;
        end else if (q.cnt >= last) begin
            d.cnt = 3'h0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 3'h1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            q <= DIV_RESET;
        end else begin
            q <= d;
        end
    end

    assign o_tick = q.tick;
endmodule

// file: hw/adc_mode_input_config.sv
// Top of the converter mode, clock divider, crosspoint and full-scale trim configuration.
// Registers are written and read back over the serial control port only.
`timescale 1ns/100ps

module adc_mode_input_config
    import adc_cfg_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sclk,
    input wire logic i_spi_sdata,
    output logic o_spi_sdout,
    output logic o_spi_sdout_oe_n,
    output adc_cfg_pkg::mode_type o_mode,
    output logic o_mode_valid,
    output logic o_precision_en,
    output logic [2:0] o_interleave_sel,
    output logic [3:0] o_branches_per_chan,
    output adc_cfg_pkg::chan_mask_type o_chan_conv_mask,
    output logic [1:0] o_clk_div_code,
    output logic [3:0] o_clk_div_factor,
    output logic o_sample_tick,
    output adc_cfg_pkg::xp_array_type o_conv_src,
    output adc_cfg_pkg::input_idx_type o_conv_input_idx,
    output logic [3:0] o_conv_src_legal,
    output logic o_xp_conflict,
    output logic [5:0] o_fs_trim_code,
    output logic signed [6:0] o_fs_trim_steps,
    output logic o_reinit_pulse
);
    import adc_cfg_pkg::*;

    typedef struct packed {
        logic reinit;
        logic precision;
        logic [2:0] interleave;
        logic [1:0] clk_div;
        xp_array_type xp;
        logic [5:0] trim;
        mode_type mode;
        logic mode_valid;
        logic [3:0] branches;
        chan_mask_type chan_mask;
        logic [3:0] div_factor;
        input_idx_type idx;
        logic [3:0] legal;
        logic conflict;
        logic signed [6:0] trim_steps;
        logic reinit_pulse;
    } cfg_state_type;

    localparam xp_array_type RST_XP = {XP_INPUT_4, XP_INPUT_3, XP_INPUT_2, XP_INPUT_1};

    localparam cfg_state_type CFG_RESET = '{
        reinit: 1'b0,
        precision: RST_PRECISION,
        interleave: RST_INTERLEAVE,
        clk_div: RST_CLK_DIV,
        xp: RST_XP,
        trim: RST_TRIM,
        mode: MODE_QUAD,
        mode_valid: 1'b1,
        branches: BRANCHES_QUAD,
        chan_mask: {4'h8, 4'h4, 4'h2, 4'h1},
        div_factor: 4'h1,
        idx: {2'h3, 2'h2, 2'h1, 2'h0},
        legal: 4'hf,
        conflict: 1'b0,
        trim_steps: 7'sh00,
        reinit_pulse: 1'b0
    };

    cfg_state_type q, d;
    cfg_bus_if bus ();

    // Mode from the four mutually exclusive bits; any other pattern is flagged
    function automatic mode_type decode_mode(input logic prec, input logic [2:0] ilv);
        mode_type m;
        m = MODE_INVALID;
        if (prec && ilv == 3'h0) begin
            m = MODE_PRECISION;
        end else if (!prec) begin
            unique case (ilv)
                ILV_SINGLE: m = MODE_SINGLE;
                ILV_DUAL: m = MODE_DUAL;
                ILV_QUAD: m = MODE_QUAD;
                default: m = MODE_INVALID;
            endcase
        end
        return m;
    endfunction

    // Source code to input index; illegal codes fall back to input 1
    function automatic logic [1:0] src_to_idx(input logic [4:0] src);
        logic [1:0] idx;
        idx = 2'h0;
        unique case (src)
            XP_INPUT_1: idx = 2'h0;
            XP_INPUT_2: idx = 2'h1;
            XP_INPUT_3: idx = 2'h2;
            XP_INPUT_4: idx = 2'h3;
            default: idx = 2'h0;
        endcase
        return idx;
    endfunction

    function automatic logic src_is_legal(input logic [4:0] src);
        return (src == XP_INPUT_1) || (src == XP_INPUT_2) || (src == XP_INPUT_3) || (src == XP_INPUT_4);
    endfunction

    function automatic logic [15:0] read_reg(input cfg_state_type s, input logic [7:0] addr);
        logic [15:0] v;
        v = 16'h0000;
        unique case (addr)
            ADDR_SOFTWARE_REINIT: v[REINIT_BIT] = s.reinit;
            ADDR_OPERATING_MODE_AND_DIVIDER: begin
                v[PRECISION_BIT] = s.precision;
                v[INTERLEAVE_LSB +: INTERLEAVE_W] = s.interleave;
                v[CLK_DIV_LSB +: CLK_DIV_W] = s.clk_div;
            end
            ADDR_CROSSPOINT_SELECT_LOW_PAIR: begin
                v[XP_LOW_LSB +: SRC_W] = s.xp[0];
                v[XP_HIGH_LSB +: SRC_W] = s.xp[1];
            end
            ADDR_CROSSPOINT_SELECT_HIGH_PAIR: begin
                v[XP_LOW_LSB +: SRC_W] = s.xp[2];
                v[XP_HIGH_LSB +: SRC_W] = s.xp[3];
            end
            ADDR_FULL_SCALE_TRIM: v[TRIM_LSB +: TRIM_W] = s.trim;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    serial_cfg_port u_port (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_spi_cs_n(i_spi_cs_n),
        .i_spi_sclk(i_spi_sclk),
        .i_spi_sdata(i_spi_sdata),
        .o_spi_sdout(o_spi_sdout),
        .o_spi_sdout_oe_n(o_spi_sdout_oe_n),
        .bus(bus.port)
    );

    assign bus.rdata = read_reg(q, bus.rd_addr);

    always_comb begin
        d = q;
        d.reinit_pulse = 1'b0;

        // Restore one cycle after the write; bit self-clears
        if (q.reinit) begin
            d.reinit = 1'b0;
            d.precision = RST_PRECISION;
            d.interleave = RST_INTERLEAVE;
            d.clk_div = RST_CLK_DIV;
            d.xp = RST_XP;
            d.trim = RST_TRIM;
            d.reinit_pulse = 1'b1;
        end

        // Writes in the restore cycle still land
        if (bus.wr_stb) begin
            unique case (bus.addr)
                ADDR_SOFTWARE_REINIT: begin
                    if (bus.wdata[REINIT_BIT]) begin
                        d.reinit = 1'b1;
                    end
                end
                ADDR_OPERATING_MODE_AND_DIVIDER: begin
                    d.precision = bus.wdata[PRECISION_BIT];
                    d.interleave = bus.wdata[INTERLEAVE_LSB +: INTERLEAVE_W];
                    d.clk_div = bus.wdata[CLK_DIV_LSB +: CLK_DIV_W];
                end
                ADDR_CROSSPOINT_SELECT_LOW_PAIR: begin
                    d.xp[0] = bus.wdata[XP_LOW_LSB +: SRC_W];
                    d.xp[1] = bus.wdata[XP_HIGH_LSB +: SRC_W];
                end
                ADDR_CROSSPOINT_SELECT_HIGH_PAIR: begin
                    d.xp[2] = bus.wdata[XP_LOW_LSB +: SRC_W];
                    d.xp[3] = bus.wdata[XP_HIGH_LSB +: SRC_W];
                end
                ADDR_FULL_SCALE_TRIM: d.trim = bus.wdata[TRIM_LSB +: TRIM_W];
                default: d.reinit = d.reinit;
            endcase
        end

        // Derived outputs follow the stored fields one cycle later
        d.mode = decode_mode(q.precision, q.interleave);
        d.mode_valid = (d.mode != MODE_INVALID);
        d.div_factor = 4'(4'h1 << q.clk_div);
        d.branches = 4'h0;
        d.chan_mask = '0;
        unique case (d.mode)
            MODE_SINGLE: begin
                d.branches = BRANCHES_SINGLE;
                d.chan_mask[0] = 4'hf;
            end
            MODE_DUAL: begin
                d.branches = BRANCHES_DUAL;
                d.chan_mask[0] = 4'h3;
                d.chan_mask[1] = 4'hc;
            end
            MODE_QUAD: begin
                d.branches = BRANCHES_QUAD;
                d.chan_mask = {4'h8, 4'h4, 4'h2, 4'h1};
            end
            MODE_PRECISION: begin
                d.branches = BRANCHES_PRECISION;
                d.chan_mask = {4'h8, 4'h4, 4'h2, 4'h1};
            end
            MODE_INVALID: begin
                d.branches = 4'h0;
                d.chan_mask = '0;
            end
        endcase

        for (int i = 0; i < NUM_CONV; i++) begin
            d.idx[i] = src_to_idx(q.xp[i]);
            d.legal[i] = src_is_legal(q.xp[i]);
        end

        // Interleaved converters of one channel must see one input
        unique case (d.mode)
            MODE_SINGLE: d.conflict = (q.xp[0] != q.xp[1]) || (q.xp[0] != q.xp[2]) || (q.xp[0] != q.xp[3]);
            MODE_DUAL: d.conflict = (q.xp[0] != q.xp[1]) || (q.xp[2] != q.xp[3]);
            MODE_QUAD, MODE_PRECISION, MODE_INVALID: d.conflict = 1'b0;
        endcase

        d.trim_steps = $signed({1'b0, q.trim}) - $signed({1'b0, TRIM_ZERO});

        if (i_rst) begin
            d = CFG_RESET;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        q <= d;
    end

    sample_clock_divider u_div (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_div_code(q.clk_div),
        .o_tick(o_sample_tick)
    );

    assign o_mode = q.mode;
    assign o_mode_valid = q.mode_valid;
    assign o_precision_en = q.precision;
    assign o_interleave_sel = q.interleave;
    assign o_branches_per_chan = q.branches;
    assign o_chan_conv_mask = q.chan_mask;
    assign o_clk_div_code = q.clk_div;
    assign o_clk_div_factor = q.div_factor;
    assign o_conv_src = q.xp;
    assign o_conv_input_idx = q.idx;
    assign o_conv_src_legal = q.legal;
    assign o_xp_conflict = q.conflict;
    assign o_fs_trim_code = q.trim;
    assign o_fs_trim_steps = q.trim_steps;
    assign o_reinit_pulse = q.reinit_pulse;
endmodule

// file: sim/adc_mode_input_config_asserts.sv
// Port-level checks for the configuration block.
// Bound onto the block from the bench; sees only its ports.
`timescale 1ns/100ps
module adc_mode_input_config_asserts
    import adc_cfg_pkg::*;
(
    input logic i_clk_sys,
    input logic i_rst,
    input adc_cfg_pkg::mode_type o_mode,
    input logic o_precision_en,
    input logic [2:0] o_interleave_sel,
    input logic [3:0] o_branches_per_chan,
    input adc_cfg_pkg::chan_mask_type o_chan_conv_mask,
    input logic [1:0] o_clk_div_code,
    input logic [3:0] o_clk_div_factor,
    input logic o_sample_tick,
    input adc_cfg_pkg::xp_array_type o_conv_src,
    input adc_cfg_pkg::input_idx_type o_conv_input_idx,
    input logic [3:0] o_conv_src_legal,
    input logic [5:0] o_fs_trim_code,
    input logic signed [6:0] o_fs_trim_steps,
    input logic o_reinit_pulse
);
    default clocking cb_sys @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    function automatic mode_type mode_of(logic p, logic [2:0] s);
        if ({p, s} == 4'h1) return MODE_SINGLE;
        if ({p, s} == 4'h2) return MODE_DUAL;
        if ({p, s} == 4'h4) return MODE_QUAD;
        if ({p, s} == 4'h8) return MODE_PRECISION;
        return MODE_INVALID;
    endfunction

    // Returns {legal, index}
    function automatic logic [2:0] src_of(logic [4:0] c);
        return (c == XP_INPUT_1) ? 3'h4 : (c == XP_INPUT_2) ? 3'h5 : (c == XP_INPUT_3) ? 3'h6 :
            (c == XP_INPUT_4) ? 3'h7 : 3'h0;
    endfunction

    // Period judged only between undisturbed ticks
    logic [3:0] gap_q;
    logic clean_q;
    logic [1:0] code_q;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            gap_q <= 4'h0;
            clean_q <= 1'b0;
            code_q <= 2'h0;
        end else begin
            code_q <= o_clk_div_code;
            gap_q <= o_sample_tick ? 4'h1 : gap_q + 4'h1;
            clean_q <= (code_q != o_clk_div_code) ? 1'b0 : (o_sample_tick | clean_q);
        end
    end

    a_mode_decode: assert property (o_mode == mode_of($past(o_precision_en), $past(o_interleave_sel)))
        else $error("mode does not follow stored bits");
    a_single_all: assert property (o_mode == MODE_SINGLE |-> o_branches_per_chan == BRANCHES_SINGLE
        && o_chan_conv_mask == 16'h000f) else $error("single mode mapping wrong");
    a_dual_pairs: assert property (o_mode == MODE_DUAL |-> o_branches_per_chan == BRANCHES_DUAL
        && o_chan_conv_mask == 16'h00c3) else $error("dual mode mapping wrong");
    a_quad_direct: assert property (o_mode == MODE_QUAD |-> o_branches_per_chan == BRANCHES_QUAD
        && o_chan_conv_mask == 16'h8421) else $error("quad mode mapping wrong");
    a_precision_one: assert property (o_mode == MODE_PRECISION |-> o_branches_per_chan == 4'h1
        && o_chan_conv_mask == 16'h8421) else $error("precision mode mapping wrong");
    a_div_factor: assert property (o_clk_div_factor == 4'h1 << $past(o_clk_div_code))
        else $error("divider factor wrong");
    a_tick_period: assert property (o_sample_tick && clean_q |-> gap_q == o_clk_div_factor)
        else $error("sample tick period wrong");
    a_trim_offset: assert property (o_fs_trim_steps == $signed({1'b0, $past(o_fs_trim_code)}) - 7'sd32)
        else $error("trim steps not offset binary");
    a_src_decode: assert property ({o_conv_src_legal[0], o_conv_input_idx[0]} == src_of($past(o_conv_src[0]))
        && {o_conv_src_legal[3], o_conv_input_idx[3]} == src_of($past(o_conv_src[3])))
        else $error("source decode wrong");
    a_reinit_defaults: assert property (o_reinit_pulse |=> o_interleave_sel == RST_INTERLEAVE
        && o_precision_en == RST_PRECISION && o_clk_div_code == RST_CLK_DIV && o_fs_trim_code == RST_TRIM
        && o_conv_src == {XP_INPUT_4, XP_INPUT_3, XP_INPUT_2, XP_INPUT_1}) else $error("reinit left state");
    a_pulse_single: assert property (o_reinit_pulse |=> !o_reinit_pulse)
        else $error("reinit pulse too long");

    c_dual: cover property (o_mode == MODE_DUAL);
    c_reinit: cover property (o_reinit_pulse);
    c_slow_tick: cover property (o_sample_tick && o_clk_div_factor == 4'h8);
endmodule

// file: sim/spi_host_model.sv
// Serial host model: 24-bit frames, address byte then 16 data bits, MSB first.
// Clock idles low between frames; data line toggles while deselected.
`timescale 1ns/100ps
module spi_host_model
#(
    parameter int HALF = 6
)
(
    input logic i_clk_sys,
    input logic i_sdout,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_sdata
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_sdata = 1'b0;
    end

    // No stale level outside a frame
    always @(negedge i_clk_sys) begin
        if (o_cs_n) o_sdata <= ~o_sdata;
    end

    // Half period above the four-clock minimum; covers readback latency
    task automatic xfer(input logic [7:0] addr, input logic [15:0] wdata, output logic [15:0] rdata);
        logic [23:0] frame;
        frame = {addr, wdata};
        rdata = 16'h0;
        @(negedge i_clk_sys);
        o_cs_n = 1'b0;
        repeat (HALF) @(negedge i_clk_sys);
        for (int b = 23; b >= 0; b--) begin
            o_sdata = frame[b];
            repeat (HALF) @(negedge i_clk_sys);
            o_sclk = 1'b1;
            if (b < 16) rdata[b] = i_sdout;
            repeat (HALF) @(negedge i_clk_sys);
            o_sclk = 1'b0;
        end
        repeat (HALF) @(negedge i_clk_sys);
        o_cs_n = 1'b1;
        repeat (HALF) @(negedge i_clk_sys);
    endtask
endmodule

// file: sim/adc_mode_input_config_tb.sv
// Self-checking bench for the mode, divider, crosspoint and trim configuration.
// Serial host model drives all registers; checker bound below.
`timescale 1ns/100ps
module adc_mode_input_config_tb;
    import adc_cfg_pkg::*;
    logic i_clk_sys;
    logic i_rst;
    logic cs_n, sclk, sdata, sdout, sdout_oe_n, mode_valid, precision_en, sample_tick, xp_conflict, reinit_pulse;
    mode_type mode;
    logic [2:0] interleave_sel;
    logic [3:0] branches, div_factor, src_legal;
    chan_mask_type conv_mask;
    logic [1:0] div_code;
    xp_array_type conv_src;
    input_idx_type input_idx;
    logic [5:0] trim_code;
    logic signed [6:0] trim_steps;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    int n_pulse = 0;
    integer seed = 32'he12d7cb0;
    logic [15:0] rdat;

    adc_mode_input_config adc_mode_input_config_i (.i_clk_sys, .i_rst, .i_spi_cs_n(cs_n),
        .i_spi_sclk(sclk), .i_spi_sdata(sdata), .o_spi_sdout(sdout), .o_spi_sdout_oe_n(sdout_oe_n),
        .o_mode(mode), .o_mode_valid(mode_valid), .o_precision_en(precision_en),
        .o_interleave_sel(interleave_sel), .o_branches_per_chan(branches), .o_chan_conv_mask(conv_mask),
        .o_clk_div_code(div_code), .o_clk_div_factor(div_factor), .o_sample_tick(sample_tick),
        .o_conv_src(conv_src), .o_conv_input_idx(input_idx), .o_conv_src_legal(src_legal),
        .o_xp_conflict(xp_conflict), .o_fs_trim_code(trim_code), .o_fs_trim_steps(trim_steps),
        .o_reinit_pulse(reinit_pulse));
    spi_host_model spi_host_model_i (.i_clk_sys(i_clk_sys), .i_sdout(sdout), .o_cs_n(cs_n), .o_sclk(sclk),
        .o_sdata(sdata));

    initial begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Roughly 45 frames of about 310 clocks each
    always @(negedge i_clk_sys) begin
        cycles++;
        if (reinit_pulse === 1'b1) n_pulse++;
        if (cycles == 40000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] unused;
        spi_host_model_i.xfer(a, d, unused);
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        spi_host_model_i.xfer(a | 8'h80, 16'h0, d);
    endtask

    function automatic logic [15:0] dflt(logic [7:0] a);
        case (a)
            ADDR_OPERATING_MODE_AND_DIVIDER: return {6'h0, RST_CLK_DIV, 4'h0, RST_PRECISION, RST_INTERLEAVE};
            ADDR_CROSSPOINT_SELECT_LOW_PAIR: return {3'h0, XP_INPUT_2, 3'h0, XP_INPUT_1};
            ADDR_CROSSPOINT_SELECT_HIGH_PAIR: return {3'h0, XP_INPUT_4, 3'h0, XP_INPUT_3};
            ADDR_FULL_SCALE_TRIM: return {10'h0, RST_TRIM};
            default: return 16'h0;
        endcase
    endfunction

    function automatic chan_mask_type exp_mask(int m);
        return (m == 0) ? 16'h000f : (m == 1) ? 16'h00c3 : 16'h8421;
    endfunction

    // Last address is unmapped and must read zero
    task automatic chk_defaults();
        logic [7:0] a [6];
        logic [15:0] d;
        a = '{ADDR_SOFTWARE_REINIT, ADDR_OPERATING_MODE_AND_DIVIDER, ADDR_CROSSPOINT_SELECT_LOW_PAIR,
              ADDR_CROSSPOINT_SELECT_HIGH_PAIR, ADDR_FULL_SCALE_TRIM, 8'h20};
        foreach (a[j]) begin
            rd(a[j], d);
            check(32'(d), 32'(dflt(a[j])));
        end
        check(32'(sdout_oe_n), 32'h1);
    endtask

    task automatic meas(output logic [15:0] p);
        for (int n = 0; sample_tick !== 1'b1 && n < 40; n++) @(negedge i_clk_sys);
        p = 16'h0;
        do begin
            @(negedge i_clk_sys);
            p++;
        end while (sample_tick !== 1'b1 && p < 16'd40);
    endtask

    initial begin
        int k;
        int ix [4];
        logic [4:0] c [4];
        logic [15:0] p;
        logic [5:0] t;
        i_rst = 1'b1;
        repeat (8) @(negedge i_clk_sys);
        i_rst = 1'b0;
        repeat (3) @(negedge i_clk_sys);
        chk_defaults();
        $display("test defaults done");
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_OPERATING_MODE_AND_DIVIDER, {6'h0, 2'(m), 4'h0, 4'h1 << m});
            check(32'(mode), 32'(m));
            check(32'(mode_valid), 32'h1);
            check(32'(branches), (m == 3) ? 32'h1 : 32'h8 >> m);
            check(32'(conv_mask), 32'(exp_mask(m)));
            check(32'(div_factor), 32'h1 << m);
            meas(p);
            check(32'(p), 32'h1 << m);
            rd(ADDR_OPERATING_MODE_AND_DIVIDER, rdat);
            check(32'(rdat), 32'({6'h0, 2'(m), 4'h0, 4'h1 << m}));
        end
        $display("test modes done");
        wr(ADDR_OPERATING_MODE_AND_DIVIDER, 16'h0004);
        for (int i = 0; i < 6; i++) begin
            for (int v = 0; v < 4; v++) begin
                k = $random(seed);
                ix[v] = k & 3;
                c[v] = XP_INPUT_1 << k[1:0];
            end
            // First pass: illegal code on converter one
            if (i == 0) c[0] = 5'h01;
            if (i == 0) ix[0] = 0;
            wr(ADDR_CROSSPOINT_SELECT_LOW_PAIR, {3'h0, c[1], 3'h0, c[0]});
            wr(ADDR_CROSSPOINT_SELECT_HIGH_PAIR, {3'h0, c[3], 3'h0, c[2]});
            check(32'({c[3], c[2], c[1], c[0]}), 32'(conv_src));
            check(32'(input_idx), 32'({2'(ix[3]), 2'(ix[2]), 2'(ix[1]), 2'(ix[0])}));
            check(32'(src_legal), (i == 0) ? 32'he : 32'hf);
            check(32'(xp_conflict), 32'h0);
            rd(ADDR_CROSSPOINT_SELECT_HIGH_PAIR, rdat);
            check(32'(rdat), 32'({3'h0, c[3], 3'h0, c[2]}));
        end
        $display("test crosspoint done");
        for (int i = 0; i < 6; i++) begin
            k = $random(seed);
            t = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : (i == 2) ? TRIM_ZERO : k[5:0];
            wr(ADDR_FULL_SCALE_TRIM, {10'h0, t});
            check(32'(trim_code), 32'(t));
            check(32'(trim_steps), 32'($signed({1'b0, t}) - 7'sd32));
        end
        $display("test trim done");
        wr(ADDR_OPERATING_MODE_AND_DIVIDER, 16'h0301);
        n_pulse = 0;
        wr(ADDR_SOFTWARE_REINIT, 16'h0001);
        check(32'(n_pulse), 32'h1);
        check(32'(mode), 32'(MODE_QUAD));
        chk_defaults();
        $display("test reinit done");
        complete_run();
    end
endmodule

bind adc_mode_input_config adc_mode_input_config_asserts adc_mode_input_config_asserts_i (.*);
